// [verilog/its_send_params.svh]
`ifndef ITS_SEND_PARAMS_SVH
`define ITS_SEND_PARAMS_SVH
`define RETRY_LIMIT_DEF  4'h3
`define OUTSTANDING_W    4
`define OFS_W            32
`define TAG_W            16
`define ADDR_W           64
`define CNT_ZERO         4'h0
`define CNT_ONE          4'h1
`define OFS_ZERO         32'h0000_0000
`endif

// [verilog/its_send_pkg.sv]
`include "its_send_params.svh"
package its_send_pkg;
  typedef enum logic [1:0] {FK_NONE, FK_CMD, FK_TASK, FK_DATA} frame_kind_t;
  typedef enum logic [2:0] {
    TS_FRAME_TX, TS_ACK, TS_NAK, TS_TIMEOUT, TS_CONN_LOST, TS_CANCEL_ACK,
    TS_OTHER
  } tx_status_t;
  typedef enum logic [3:0] {
    CM_NONE, CM_CMD_TMO, CM_TASK_TMO, CM_CMD_NAK, CM_TASK_NAK,
    CM_DOUT_NAK, CM_DOUT_TMO, CM_CANCEL_ACK, CM_XR_LEN, CM_XR_OFS
  } cmpl_code_t;
  typedef struct packed {
    logic [`OFS_W-1:0] req_offset;
    logic [`OFS_W-1:0] wr_len;
    logic              retry_data;
    logic              retransmit;
  } xfer_rdy_t;
  typedef struct packed {
    logic              valid;
    tx_status_t        status;
  } confirm_t;
  typedef struct packed {
    logic              valid;
    cmpl_code_t        code;
    logic [`TAG_W-1:0] tag;
  } cmpl_t;
  typedef struct packed {
    logic               valid;
    logic [`ADDR_W-1:0] dest_addr;
    logic [`TAG_W-1:0]  tag;
  } cancel_req_t;
endpackage

// [verilog/xfer_rdy_check.sv]
`include "its_send_params.svh"
module xfer_rdy_check (
  // Clock and reset
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst_n,
  // Arriving transfer-ready
  input  wire logic                  i_valid,
  input  wire its_send_pkg::xfer_rdy_t i_xr,
  input  wire logic [`OFS_W-1:0]     i_buf_size,
  input  wire logic [`OFS_W-1:0]     i_prev_ofs,
  input  wire logic [`OFS_W-1:0]     i_prev_len,
  input  wire logic                  i_first,
  input  wire logic                  i_retry_en,
  // Verdict, one cycle later
  output logic                       o_done,
  output its_send_pkg::cmpl_code_t   o_code
);
  import its_send_pkg::*;
  typedef struct packed {
    logic       done;
    cmpl_code_t code;
  } chk_state_t;
  chk_state_t st_ff, nxt_st;
  logic [`OFS_W:0] end_ofs;
  logic            len_bad;
  logic            ofs_bad;
  always_comb begin
    end_ofs = {1'b0, i_xr.req_offset} + {1'b0, i_xr.wr_len};
    len_bad = (i_xr.wr_len == `OFS_ZERO) ||
              (end_ofs > {1'b0, i_buf_size});
    // Only the simplest sequencing check is kept here.
    ofs_bad = i_first ? (i_xr.req_offset != `OFS_ZERO) :
              (!i_xr.retransmit || !i_retry_en) &&
              (i_xr.req_offset != i_prev_ofs + i_prev_len);
    nxt_st.done = i_valid;
    nxt_st.code = CM_NONE;
    if (len_bad) begin
      nxt_st.code = CM_XR_LEN;
    end else if (ofs_bad) begin
      nxt_st.code = CM_XR_OFS;
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign o_done = st_ff.done;
  assign o_code = st_ff.code;
  chk_len_priority: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_valid && i_xr.wr_len == `OFS_ZERO) |=> o_code == CM_XR_LEN)
    else $error("Zero length not reported as length error.");
endmodule // xfer_rdy_check

// [verilog/its_send.sv]
`include "its_send_params.svh"
module its_send (
  // Clock and reset
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rst_n,
  // Router side
  input  wire logic                      i_send_cmd,
  input  wire logic                      i_send_task,
  input  wire logic                      i_send_data,
  input  wire logic                      i_cancel,
  input  wire logic                      i_return_start,
  input  wire logic [`TAG_W-1:0]         i_tag,
  input  wire logic [`ADDR_W-1:0]        i_dest_addr,
  input  wire logic                      i_xr_arrived,
  input  wire its_send_pkg::xfer_rdy_t   i_xr,
  input  wire logic [`OFS_W-1:0]         i_buf_size,
  input  wire logic                      i_retry_en,
  input  wire logic [3:0]                i_retry_limit,
  output its_send_pkg::cmpl_t            o_cmpl,
  output logic [`OFS_W-1:0]              o_dout_ofs,
  output logic [`OFS_W-1:0]              o_prev_ofs,
  // Port layer side
  input  wire its_send_pkg::confirm_t    i_conf,
  output logic                           o_tx_req,
  output its_send_pkg::frame_kind_t      o_tx_kind,
  output logic                           o_tx_interlocked,
  output its_send_pkg::cancel_req_t      o_cancel_req,
  output logic                           o_active
);
  import its_send_pkg::*;
  typedef enum logic [1:0] {S_START, S_SEND, S_WAIT_ACK} phase_t;
  typedef struct packed {
    phase_t                   phase;
    frame_kind_t              kind;
    logic                     retry_data;
    logic [3:0]               retries;
    logic [`OUTSTANDING_W-1:0] pending;
    logic                     first_xr;
    logic [`OFS_W-1:0]        dout_ofs;
    logic [`OFS_W-1:0]        prev_ofs;
    logic [`OFS_W-1:0]        prev_len;
    logic                     tx_req;
    logic                     tx_il;
    cmpl_t                    cmpl;
    cancel_req_t              cxl;
    logic [`TAG_W-1:0]        tag;
    logic [`ADDR_W-1:0]       dest;
  } its_state_t;
  its_state_t st_ff, nxt_st;
  logic       chk_done;
  cmpl_code_t chk_code;
  logic       at_limit;
  logic       lost;
  logic       conf_done;
  function automatic cmpl_t mk(input cmpl_code_t c,
                               input logic [`TAG_W-1:0] t);
    mk.valid = 1'b1;
    mk.code  = c;
    mk.tag   = t;
  endfunction
  xfer_rdy_check u_chk (
    .i_ref_clk  (i_ref_clk),
    .i_rst_n    (i_rst_n),
    .i_valid    (i_xr_arrived),
    .i_xr       (i_xr),
    .i_buf_size (i_buf_size),
    .i_prev_ofs (st_ff.prev_ofs),
    .i_prev_len (st_ff.prev_len),
    .i_first    (st_ff.first_xr),
    .i_retry_en (i_retry_en),
    .o_done     (chk_done),
    .o_code     (chk_code)
  );
  always_comb begin
    at_limit = (st_ff.retries >= i_retry_limit);
    lost = i_conf.valid && (i_conf.status == TS_TIMEOUT ||
                            i_conf.status == TS_CONN_LOST);
    nxt_st = st_ff;
    nxt_st.tx_req = 1'b0;
    nxt_st.cmpl = '0;
    nxt_st.cxl = '0;
    conf_done = i_conf.valid && i_conf.status != TS_FRAME_TX &&
                st_ff.pending != `CNT_ZERO;
    // A request and a confirmation in one cycle cancel out, so neither
    // is lost from the count.
    if (st_ff.tx_req && !conf_done) begin
      nxt_st.pending = st_ff.pending + `CNT_ONE;
    end else if (conf_done && !st_ff.tx_req) begin
      nxt_st.pending = st_ff.pending - `CNT_ONE;
    end
    unique case (st_ff.phase)
      S_START: begin
        nxt_st.dout_ofs = `OFS_ZERO;
        nxt_st.first_xr = 1'b1;
        if (i_send_cmd || i_send_task) begin
          nxt_st.kind = i_send_cmd ? FK_CMD : FK_TASK;
          nxt_st.tag = i_tag;
          nxt_st.dest = i_dest_addr;
          nxt_st.retries = `CNT_ZERO;
          nxt_st.tx_req = 1'b1;
          nxt_st.tx_il = 1'b1;
          nxt_st.phase = S_SEND;
        end
      end
      S_SEND, S_WAIT_ACK: begin
        if (i_send_data && st_ff.phase == S_SEND) begin
          nxt_st.kind = FK_DATA;
          nxt_st.retries = `CNT_ZERO;
          nxt_st.tx_req = 1'b1;
          nxt_st.tx_il = 1'b0;
        end
        if (i_conf.valid && i_conf.status == TS_FRAME_TX) begin
          nxt_st.phase = S_WAIT_ACK;
        end else if (i_conf.valid && i_conf.status == TS_NAK &&
                     st_ff.phase == S_WAIT_ACK) begin
          if (st_ff.kind != FK_DATA && !at_limit) begin
            nxt_st.retries = st_ff.retries + `CNT_ONE;
            nxt_st.tx_req = 1'b1;
            nxt_st.tx_il = 1'b1;
            nxt_st.phase = S_SEND;
          end else if (st_ff.kind == FK_CMD) begin
            nxt_st.cmpl = mk(CM_CMD_NAK, st_ff.tag);
            nxt_st.phase = S_START;
          end else if (st_ff.kind == FK_TASK) begin
            nxt_st.cmpl = mk(CM_TASK_NAK, st_ff.tag);
            nxt_st.phase = S_START;
          end else if (!st_ff.retry_data || at_limit) begin
            nxt_st.cmpl = mk(CM_DOUT_NAK, st_ff.tag);
            nxt_st.phase = S_START;
          end else begin
            nxt_st.retries = st_ff.retries + `CNT_ONE;
            nxt_st.tx_req = 1'b1;
            nxt_st.phase = S_SEND;
          end
        end else if (lost && st_ff.phase == S_WAIT_ACK) begin
          if (st_ff.kind == FK_CMD) begin
            // Stays active so a later status can still finish it.
            nxt_st.cmpl = mk(CM_CMD_TMO, st_ff.tag);
          end else if (st_ff.kind == FK_TASK) begin
            nxt_st.cmpl = mk(CM_TASK_TMO, st_ff.tag);
            nxt_st.phase = S_START;
          end else if (!st_ff.retry_data || at_limit) begin
            nxt_st.cmpl = mk(CM_DOUT_TMO, st_ff.tag);
            nxt_st.phase = S_START;
          end else begin
            nxt_st.retries = st_ff.retries + `CNT_ONE;
            nxt_st.tx_req = 1'b1;
            nxt_st.phase = S_SEND;
          end
        end else if (i_conf.valid && i_conf.status == TS_CANCEL_ACK) begin
          nxt_st.cmpl = mk(CM_CANCEL_ACK, st_ff.tag);
        end else if (i_conf.valid && i_conf.status == TS_ACK) begin
          nxt_st.phase = S_SEND;
        end
        if (i_return_start || i_cancel) begin
          if (st_ff.pending != `CNT_ZERO || st_ff.tx_req) begin
            nxt_st.cxl.valid = 1'b1;
            nxt_st.cxl.dest_addr = st_ff.dest;
            nxt_st.cxl.tag = st_ff.tag;
          end else if (i_cancel) begin
            nxt_st.cmpl = mk(CM_CANCEL_ACK, st_ff.tag);
          end
        end
        if (i_xr_arrived) begin
          nxt_st.retry_data = i_xr.retry_data;
        end
        if (chk_done) begin
          if (chk_code != CM_NONE) begin
            nxt_st.cmpl = mk(chk_code, st_ff.tag);
            nxt_st.phase = S_START;
          end else begin
            nxt_st.first_xr = 1'b0;
            nxt_st.dout_ofs = i_xr.req_offset;
            nxt_st.prev_ofs = i_xr.req_offset;
            nxt_st.prev_len = i_xr.wr_len;
          end
        end
      end
      default: nxt_st.phase = S_START;
    endcase
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign o_cmpl = st_ff.cmpl;
  assign o_dout_ofs = st_ff.dout_ofs;
  assign o_prev_ofs = st_ff.prev_ofs;
  assign o_tx_req = st_ff.tx_req;
  assign o_tx_kind = st_ff.kind;
  assign o_tx_interlocked = st_ff.tx_il;
  assign o_cancel_req = st_ff.cxl;
  assign o_active = (st_ff.phase != S_START);

  sequence nak_seen;
    i_conf.valid && i_conf.status == TS_NAK && st_ff.phase == S_WAIT_ACK &&
    !i_return_start && !i_cancel && !chk_done;
  endsequence
  chk_cmd_resend: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    nak_seen and (st_ff.kind == FK_CMD && !at_limit)
    |=> o_tx_req && o_tx_interlocked && o_tx_kind == FK_CMD)
    else $error("Command not resent after NAK.");
  chk_task_resend: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    nak_seen and (st_ff.kind == FK_TASK && !at_limit)
    |=> o_tx_req && o_tx_interlocked && o_tx_kind == FK_TASK)
    else $error("Task not resent after NAK.");
  chk_cmd_nak: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    nak_seen and (st_ff.kind == FK_CMD && at_limit)
    |=> o_cmpl.valid && o_cmpl.code == CM_CMD_NAK && !o_active)
    else $error("Command NAK at limit not reported.");
  chk_task_nak: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    nak_seen and (st_ff.kind == FK_TASK && at_limit)
    |=> o_cmpl.valid && o_cmpl.code == CM_TASK_NAK && !o_active)
    else $error("Task NAK at limit not reported.");
  chk_cmd_timeout: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (lost && st_ff.phase == S_WAIT_ACK && st_ff.kind == FK_CMD &&
     !i_cancel && !i_return_start && !chk_done)
    |=> o_cmpl.code == CM_CMD_TMO && o_active)
    else $error("Command timeout wrong.");
  chk_task_timeout: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (lost && st_ff.phase == S_WAIT_ACK && st_ff.kind == FK_TASK &&
     !i_cancel && !i_return_start && !chk_done)
    |=> o_cmpl.code == CM_TASK_TMO && !o_active)
    else $error("Task timeout wrong.");
  chk_cancel_fwd: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    ((i_cancel || i_return_start) && o_active && st_ff.pending != `CNT_ZERO)
    |=> o_cancel_req.valid && o_cancel_req.tag == $past(st_ff.tag))
    else $error("Cancel not forwarded to port.");
  chk_cancel_ack: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_cancel && o_active && st_ff.pending == `CNT_ZERO && !st_ff.tx_req &&
     !chk_done) |=> o_cmpl.code == CM_CANCEL_ACK)
    else $error("Direct cancel acknowledge missing.");
  chk_xr_load: assert property (
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (chk_done && chk_code == CM_NONE && o_active)
    |=> o_dout_ofs == $past(i_xr.req_offset))
    else $error("Offset not loaded after check.");
endmodule // its_send

// [verif/port_layer_model.sv]
// Port layer stand-in: answers each transmit request made while not held with Frame
// Transmitted and then the status the bench chose, after a chosen delay.
module port_layer_model
  import its_send_pkg::*;
(
  // Clock and reset
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_rst_n,
  // Requests from the sender
  input  wire logic                     i_tx_req,
  input  wire logic                     i_cancel_req,
  // Bench controls
  input  wire logic                     i_hold,
  input  wire logic [1:0]               i_dly,
  input  wire its_send_pkg::tx_status_t i_ans,
  // Confirmations
  output its_send_pkg::confirm_t        o_conf
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cnt_ff;
  logic       ans_ff;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= 3'h0;
      ans_ff <= 1'b0;
      o_conf <= '0;
    end else begin
      o_conf <= '0;
      ans_ff <= 1'b0;
      // A held request is never confirmed, so it stays outstanding.
      if (i_tx_req && !i_hold)
        cnt_ff <= {1'b0, i_dly} + 3'h1;
      else if (cnt_ff != 3'h0)
        cnt_ff <= cnt_ff - 3'h1;
      if (cnt_ff == 3'h1) begin
        o_conf <= '{1'b1, TS_FRAME_TX};
        ans_ff <= 1'b1;
      end
      if (ans_ff)
        o_conf <= '{1'b1, i_ans};
      if (i_cancel_req && !i_hold)
        o_conf <= '{1'b1, TS_CANCEL_ACK};
    end
  end
endmodule // port_layer_model

// [verif/its_send_tb.sv]
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
  fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, got, \
  exp); end end
module its_send_tb import its_send_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk, i_rst_n, i_send_cmd, i_send_task, i_send_data;
  logic i_cancel, i_return_start, i_xr_arrived, i_retry_en, hold;
  logic [15:0] i_tag;
  logic [63:0] i_dest_addr;
  logic [31:0] i_buf_size, o_dout_ofs, o_prev_ofs, seed, obs, exp_q[$];
  logic [3:0] i_retry_limit;
  logic [1:0] dly;
  xfer_rdy_t i_xr;
  confirm_t i_conf;
  cmpl_t o_cmpl;
  cancel_req_t o_cancel_req;
  frame_kind_t o_tx_kind, k;
  tx_status_t ans;
  logic o_tx_req, o_tx_interlocked, o_active;
  int fail_count, samples_checked, lim;
  its_send its_send_i (.i_ref_clk, .i_rst_n, .i_send_cmd, .i_send_task,
    .i_send_data, .i_cancel, .i_return_start, .i_tag, .i_dest_addr,
    .i_xr_arrived, .i_xr, .i_buf_size, .i_retry_en, .i_retry_limit,
    .o_cmpl, .o_dout_ofs, .o_prev_ofs, .i_conf, .o_tx_req, .o_tx_kind,
    .o_tx_interlocked, .o_cancel_req, .o_active);
  port_layer_model port_layer_model_i (.i_ref_clk, .i_rst_n,
    .i_tx_req(o_tx_req), .i_cancel_req(o_cancel_req.valid),
    .i_hold(hold), .i_dly(dly), .i_ans(ans), .o_conf(i_conf));
  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask
  function automatic logic [31:0] cn(cmpl_code_t c);
    return {4'h2, i_tag[11:0], 12'h000, c};
  endfunction
  function automatic logic [31:0] txn(frame_kind_t f);
    return {4'h1, 25'h0, f != FK_DATA, f};
  endfunction
  // Every observed output event must match the oldest note.
  always @(posedge i_ref_clk) begin
    #2;
    if (o_tx_req === 1'b1) begin
      obs = {4'h1, 25'h0, o_tx_interlocked, o_tx_kind};
      `CHK(obs, exp_q.pop_front())
    end
    if (o_cmpl.valid === 1'b1) begin
      obs = {4'h2, o_cmpl.tag[11:0], 12'h000, o_cmpl.code};
      `CHK(obs, exp_q.pop_front())
    end
    if (o_cancel_req.valid === 1'b1) begin
      obs = {4'h3, o_cancel_req.tag[11:0], o_cancel_req.dest_addr[15:0]};
      `CHK(obs, exp_q.pop_front())
    end
  end
  task automatic reset_dut();
    i_rst_n = 1'b0;
    tick(2);
    i_rst_n = 1'b1;
    i_tag = 16'($urandom);
    i_dest_addr = {$urandom, $urandom};
    tick();
  endtask
  task automatic send(frame_kind_t f, tx_status_t a, logic h);
    ans = a;
    hold = h;
    dly = 2'($urandom_range(3));
    i_send_cmd = (f == FK_CMD);
    i_send_task = (f == FK_TASK);
    i_send_data = (f == FK_DATA);
    exp_q.push_back(txn(f));
    tick();
    {i_send_cmd, i_send_task, i_send_data} = 3'h0;
  endtask
  task automatic drain();
    for (int i = 0; i < 100 && exp_q.size() != 0; i++)
      tick();
    tick(3);
    `CHK(exp_q.size(), 0)
  endtask
  initial begin
    #100us;
    fail_count++;
    test_done();
  end
  initial begin
    {i_rst_n, i_send_cmd, i_send_task, i_send_data, i_cancel} = 5'h00;
    {i_return_start, i_xr_arrived, i_retry_en, hold, dly} = 6'h00;
    {i_tag, i_dest_addr, i_xr, i_retry_limit} = '0;
    ans = TS_ACK;
    i_buf_size = 32'h0000_1000;
    seed = $urandom(32'h5f5c944c);
    tick(4);
    for (int t = 0; t < 2; t++) begin
      reset_dut();
      lim = 1 + $urandom_range(2);
      i_retry_limit = 4'(lim);
      k = t ? FK_TASK : FK_CMD;
      send(k, TS_NAK, 1'b0);
      repeat (lim) exp_q.push_back(txn(k));
      exp_q.push_back(cn(t ? CM_TASK_NAK : CM_CMD_NAK));
      drain();
      `CHK(o_active, 1'b0)
    end
    for (int t = 0; t < 4; t++) begin
      reset_dut();
      k = t[1] ? FK_TASK : FK_CMD;
      send(k, t[0] ? TS_CONN_LOST : TS_TIMEOUT, 1'b0);
      exp_q.push_back(cn(t[1] ? CM_TASK_TMO : CM_CMD_TMO));
      drain();
      `CHK(o_active, !t[1])
      i_cancel = 1'b1;
      if (!t[1]) exp_q.push_back(cn(CM_CANCEL_ACK));
      tick();
      i_cancel = 1'b0;
      drain();
    end
    for (int r = 0; r < 2; r++) begin
      reset_dut();
      send(FK_CMD, TS_ACK, 1'b1);
      tick(3);
      hold = r[0];
      i_cancel = !r[0];
      i_return_start = r[0];
      exp_q.push_back({4'h3, i_tag[11:0], i_dest_addr[15:0]});
      if (!r[0]) exp_q.push_back(cn(CM_CANCEL_ACK));
      tick();
      {i_cancel, i_return_start} = 2'h0;
      drain();
    end
    for (int x = 0; x < 6; x++) begin
      reset_dut();
      // One allowed data retry on the run with retry_data set exercises resend.
      i_retry_limit = {3'h0, x == 1};
      send(FK_CMD, TS_ACK, 1'b0);
      drain();
      i_xr = '{32'h0, 32'($urandom_range(2048, 1)), x == 1, 1'b0};
      if (x == 3) i_xr = '{32'h0000_0010, 32'h0, 1'b0, 1'b0};
      if (x == 4) i_xr.wr_len = i_buf_size + 32'h0000_0001;
      if (x == 5) i_xr.req_offset = 32'h0000_0010;
      i_xr_arrived = 1'b1;
      if (x == 5) exp_q.push_back(cn(CM_XR_OFS));
      else if (x > 2) exp_q.push_back(cn(CM_XR_LEN));
      tick();
      i_xr_arrived = 1'b0;
      tick(3);
      if (x < 3) begin
        `CHK(o_dout_ofs, 32'h0000_0000)
        `CHK(o_prev_ofs, 32'h0000_0000)
        // A follow-on request must move both offsets to its own offset.
        i_xr.req_offset = i_xr.wr_len;
        i_xr_arrived = 1'b1;
        tick();
        i_xr_arrived = 1'b0;
        tick(3);
        `CHK(o_dout_ofs, i_xr.wr_len)
        `CHK(o_prev_ofs, i_xr.wr_len)
        send(FK_DATA, x == 0 ? TS_NAK : x == 1 ? TS_TIMEOUT : TS_CONN_LOST,
          1'b0);
        if (x == 1) exp_q.push_back(txn(FK_DATA));
        exp_q.push_back(cn(x ? CM_DOUT_TMO : CM_DOUT_NAK));
      end
      drain();
    end
    test_done();
  end
endmodule // its_send_tb
